// file: rtl/erc_pkg.sv
package erc_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_PERIOD_NS = 500;
  localparam int BUS_DIV       = BUS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TMR_PRESCALE  = 8;
  localparam int TICK_NS       = 4000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_MODULUS   = 255;
  localparam int MIN_BUS_RATIO = 5;

  // ==========================================================================
  // Register map, byte offsets
  // ==========================================================================
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_STATUS     = 8'h04;
  localparam logic [7:0] OFF_RESULT     = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT   = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h10;
  localparam logic [7:0] OFF_TABLE_BASE = 8'h14;

  // Field positions.
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_PARK_BIT   = 1;
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_CMP_ON_BIT   = 1;
  localparam int ST_TMR_RUN_BIT  = 2;
  localparam int ST_CNT_LSB      = 8;
  localparam int RES_RAW_LSB     = 0;
  localparam int RES_CODE_LSB    = 8;
  localparam int RES_OOR_BIT     = 16;
  localparam int IRQ_W           = 2;
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_OOR_BIT     = 1;

  // ==========================================================================
  // Paging and table
  // ==========================================================================
  localparam logic [7:0]  TABLE_BASE_RST = 8'hf8;
  localparam logic [7:0]  REG_PAGE_RST   = 8'h00;
  localparam logic [13:0] TABLE_ADDR     = 14'h3e00;
  localparam logic [1:0]  WINDOW_HI      = 2'h3;
  localparam logic [7:0]  RAW_FULL       = 8'hff;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

  typedef enum {
    S_IDLE, S_TMR, S_CMP, S_CLR, S_WAIT, S_END, S_PAGE, S_READ
  } erc_state_e;

  // Comparator positive pin: output level and active-low output enable.
  typedef struct packed {
    logic o;
    logic oen;
  } erc_pin_s;

  typedef struct packed {
    logic start;
    logic park;
  } erc_ctrl_s;

endpackage : erc_pkg

// file: rtl/erc_top.sv
// ============================================================================
`timescale 1ns/1ps
`default_nettype none

module erc_top #(
  parameter int BUS_DIV_P  = erc_pkg::BUS_DIV,
  parameter int PRESCALE_P = erc_pkg::TMR_PRESCALE,
  parameter int MODULUS_P  = erc_pkg::TMR_MODULUS
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RSTN,
  // AHB-Lite slave
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  output logic      [31:0]      HRDATA,
  output logic                  HREADYOUT,
  output logic      [1:0]       HRESP,
  // Analog comparator
  input  wire logic             CMP_OUT,
  output logic                  CMP_ON,
  output logic                  CMP_IRQ_ON,
  input  wire logic             RC_I,
  output erc_pkg::erc_pin_s     RC_PIN,
  // Result and interrupt
  output logic      [7:0]       LINEAR_CODE,
  output logic                  DONE,
  output logic                  IRQ
);
  import erc_pkg::*;

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (PRESCALE_P < MIN_BUS_RATIO) begin : g_ratio_chk
    $error("Prescaler below minimum bus-to-tick ratio.");
  end
  if (BUS_DIV_P < 1 || BUS_DIV_P > 256 || PRESCALE_P > 256 || MODULUS_P < 1 || MODULUS_P > 255) begin : g_par_chk
    $error("Divider or modulus out of range.");
  end

  // Table contents, entry 0 in the most significant byte.
  localparam logic [2047:0] LUT_FLAT = {
    128'h00050a0e12171b1f23272b2f32363a3d,
    128'h4144474b4e5154575a5d606366696b6e,
    128'h717376787b7d7f828486888a8d8f9193,
    128'h9596989a9c9ea0a1a3a5a6a8a9abadae,
    128'hafb1b2b4b5b6b8b9babcbdbebfc0c1c3,
    128'hc4c5c6c7c8c9cacbcccdcececfd0d1d2,
    128'hd3d3d4d5d6d7d7d8d9d9dadbdbdcdddd,
    128'hdedfdfe0e0e1e1e2e2e3e4e4e4e5e5e6,
    128'he6e7e7e8e8e9e9e9eaeaebebebececec,
    128'hedededeeeeeeefefeff0f0f0f0f1f1f1,
    128'hf2f2f2f2f3f3f3f3f3f4f4f4f4f4f5f5,
    128'hf5f5f5f6f6f6f6f6f6f7f7f7f7f7f7f7,
    128'hf8f8f8f8f8f8f8f8f9f9f9f9f9f9f9f9,
    128'hf9f9f9f9fafafafafafafafafafafafa,
    128'hfbfbfbfbfbfbfbfbfbfbfbfbfbfbfbfb,
    128'hfcfcfcfcfcfcfcfcfcfcfcfcfcfdfdfd
  };

  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction : hit

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0]        lut_mem [256];
  erc_state_e        state_q;
  logic [7:0]        bus_cnt_q;
  logic              bus_en;
  logic [7:0]        pre_cnt_q;
  logic              tick;
  logic              tmr_run_q;
  logic              tmr_ovf_irq_on_q;
  logic              tmr_ovf_q;
  logic [7:0]        tmr_cnt_q;
  logic              tmr_start;
  logic              tmr_stop;
  logic              cmp_s1_q;
  logic              cmp_s2_q;
  logic              cmp_s3_q;
  logic              cmp_rise;
  logic              cmp_on_q;
  logic              cmp_irq_on_q;
  logic              cmp_flag_q;
  logic              cmp_flag_clr;
  logic              wake;
  logic [7:0]        raw_q;
  logic              oor_q;
  logic [7:0]        code_q;
  logic [7:0]        page_q;
  logic [7:0]        table_base_q;
  logic [13:0]       upper_addr;
  logic [13:0]       lut_off;
  logic [7:0]        lut_data;
  logic              done_q;
  erc_ctrl_s         ctrl_q;
  logic              start_req;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_set;
  logic              irq_q;
  logic              ap_valid;
  logic              dp_wr_q;
  logic [31:0]       dp_addr_q;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic              stat_rd;
  erc_pin_s          rc_pin_q;
  logic              rc_unused;

  for (genvar i = 0; i < 256; i++) begin : g_lut
    assign lut_mem[i] = LUT_FLAT[(255 - i) * 8 +: 8];
  end

  // RC_I is the pin read-back; the comparator already sees the analog level.
  assign rc_unused = RC_I;

  // ==========================================================================
  // Bus clock emulation and timer prescaler
  // ==========================================================================
  // The documented timing assumes a slow bus clock; it is rebuilt as an
  // enable so that the whole block still runs on CLK alone.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      bus_cnt_q <= 8'h00;
    end else if (bus_cnt_q == 8'(BUS_DIV_P - 1)) begin
      bus_cnt_q <= 8'h00;
    end else begin
      bus_cnt_q <= bus_cnt_q + 8'h01;
    end
  end
  assign bus_en = (bus_cnt_q == 8'(BUS_DIV_P - 1));

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pre_cnt_q <= 8'h00;
    end else if (tmr_start || !tmr_run_q) begin
      pre_cnt_q <= 8'h00;
    end else if (bus_en) begin
      pre_cnt_q <= (pre_cnt_q == 8'(PRESCALE_P - 1)) ? 8'h00 : pre_cnt_q + 8'h01;
    end
  end
  assign tick = tmr_run_q && bus_en && (pre_cnt_q == 8'(PRESCALE_P - 1));

  // ==========================================================================
  // Modulo counter
  // ==========================================================================
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tmr_run_q        <= 1'b0;
      tmr_ovf_irq_on_q <= 1'b0;
      tmr_ovf_q        <= 1'b0;
      tmr_cnt_q        <= 8'h00;
    end else if (tmr_start) begin
      tmr_run_q        <= 1'b1;
      tmr_ovf_irq_on_q <= 1'b1;
      tmr_ovf_q        <= 1'b0;
      tmr_cnt_q        <= 8'h00;
    end else if (tmr_stop) begin
      tmr_run_q        <= 1'b0;
      tmr_ovf_irq_on_q <= 1'b0;
      tmr_ovf_q        <= 1'b0;
      tmr_cnt_q        <= 8'h00;
    end else if (tick) begin
      if (tmr_cnt_q == 8'(MODULUS_P)) begin
        tmr_cnt_q <= 8'h00;
        tmr_ovf_q <= 1'b1;
      end else begin
        tmr_cnt_q <= tmr_cnt_q + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Comparator interface
  // ==========================================================================
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      cmp_s3_q <= 1'b0;
    end else begin
      cmp_s1_q <= CMP_OUT;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
    end
  end
  assign cmp_rise = cmp_s2_q && !cmp_s3_q;

  // A new edge in the clearing cycle wins, so no event is lost.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cmp_flag_q <= 1'b0;
    end else if (cmp_on_q && cmp_rise) begin
      cmp_flag_q <= 1'b1;
    end else if (cmp_flag_clr) begin
      cmp_flag_q <= 1'b0;
    end
  end

  assign wake = (cmp_flag_q && cmp_irq_on_q) || (tmr_ovf_q && tmr_ovf_irq_on_q);

  // ==========================================================================
  // Conversion sequence
  // ==========================================================================
  assign start_req    = ctrl_q.start && (state_q == S_IDLE);
  assign tmr_start    = (state_q == S_TMR);
  assign tmr_stop     = (state_q == S_END);
  assign cmp_flag_clr = (state_q == S_CLR) || (state_q == S_END);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE:  state_q <= start_req ? S_TMR : S_IDLE;
        S_TMR:   state_q <= S_CMP;
        S_CMP:   state_q <= S_CLR;
        S_CLR:   state_q <= S_WAIT;
        S_WAIT:  state_q <= wake ? S_END : S_WAIT;
        S_END:   state_q <= S_PAGE;
        S_PAGE:  state_q <= S_READ;
        S_READ:  state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cmp_on_q     <= 1'b0;
      cmp_irq_on_q <= 1'b0;
    end else if (state_q == S_CMP) begin
      cmp_on_q     <= 1'b1;
      cmp_irq_on_q <= 1'b1;
    end else if (state_q == S_END) begin
      cmp_on_q     <= 1'b0;
      cmp_irq_on_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      raw_q <= 8'h00;
      oor_q <= 1'b0;
    end else if (state_q == S_WAIT && wake) begin
      raw_q <= cmp_flag_q ? tmr_cnt_q : RAW_FULL;
      oor_q <= !cmp_flag_q;
    end
  end

  // ==========================================================================
  // Code translation through the paged window
  // ==========================================================================
  // Only the raw count's top bits move the page; a base that is not on a
  // 256-byte boundary still works because the page is added, not ORed.
  assign upper_addr = {page_q, raw_q[5:0]};
  assign lut_off    = upper_addr - TABLE_ADDR;
  assign lut_data   = (lut_off[13:8] == 6'h00) ? lut_mem[lut_off[7:0]] : 8'h00;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      page_q <= REG_PAGE_RST;
    end else if (state_q == S_PAGE) begin
      page_q <= table_base_q + {6'h00, raw_q[7:6]};
    end else if (state_q == S_READ) begin
      page_q <= REG_PAGE_RST;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      code_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == S_READ);
      if (state_q == S_READ && {WINDOW_HI, raw_q[5:0]} >= 8'hc0) begin
        code_q <= lut_data;
      end
    end
  end

  // ==========================================================================
  // Discharge pin
  // ==========================================================================
  // Low drive discharges the RC; parking releases it to stop the sink current.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rc_pin_q <= '{o: 1'b0, oen: 1'b0};
    end else if (cmp_on_q || (state_q == S_CMP) || ctrl_q.park) begin
      rc_pin_q <= '{o: 1'b0, oen: 1'b1};
    end else begin
      rc_pin_q <= '{o: 1'b0, oen: 1'b0};
    end
  end

  // ==========================================================================
  // Interrupt status
  // ==========================================================================
  assign irq_set[IRQ_DONE_BIT] = (state_q == S_READ);
  assign irq_set[IRQ_OOR_BIT]  = (state_q == S_END) && oor_q;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | irq_set;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ==========================================================================
  // AHB-Lite register slave
  // ==========================================================================
  assign ap_valid = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
  assign stat_rd  = ap_valid && !HWRITE && hit(HADDR, OFF_IRQ_STAT);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 32'h00000000;
    end else begin
      dp_wr_q   <= ap_valid && HWRITE;
      dp_addr_q <= ap_valid ? HADDR : dp_addr_q;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q       <= '{start: 1'b0, park: 1'b0};
      irq_mask_q   <= '0;
      table_base_q <= TABLE_BASE_RST;
    end else begin
      ctrl_q.start <= 1'b0;
      if (dp_wr_q && hit(dp_addr_q, OFF_CTRL)) begin
        ctrl_q.start <= HWDATA[CTRL_START_BIT];
        ctrl_q.park  <= HWDATA[CTRL_PARK_BIT];
      end
      if (dp_wr_q && hit(dp_addr_q, OFF_IRQ_MASK)) begin
        irq_mask_q <= HWDATA[IRQ_W-1:0];
      end
      if (dp_wr_q && hit(dp_addr_q, OFF_TABLE_BASE)) begin
        table_base_q <= HWDATA[7:0];
      end
    end
  end

  always_comb begin
    rdata_d = 32'h00000000;
    if (hit(HADDR, OFF_CTRL)) begin
      rdata_d[CTRL_PARK_BIT] = ctrl_q.park;
    end else if (hit(HADDR, OFF_STATUS)) begin
      rdata_d[ST_BUSY_BIT]              = (state_q != S_IDLE);
      rdata_d[ST_CMP_ON_BIT]            = cmp_on_q;
      rdata_d[ST_TMR_RUN_BIT]           = tmr_run_q;
      rdata_d[ST_CNT_LSB +: 8]          = tmr_cnt_q;
    end else if (hit(HADDR, OFF_RESULT)) begin
      rdata_d[RES_RAW_LSB +: 8]         = raw_q;
      rdata_d[RES_CODE_LSB +: 8]        = code_q;
      rdata_d[RES_OOR_BIT]              = oor_q;
    end else if (hit(HADDR, OFF_IRQ_STAT)) begin
      rdata_d[IRQ_W-1:0]                = irq_stat_q;
    end else if (hit(HADDR, OFF_IRQ_MASK)) begin
      rdata_d[IRQ_W-1:0]                = irq_mask_q;
    end else if (hit(HADDR, OFF_TABLE_BASE)) begin
      rdata_d[7:0]                      = table_base_q;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= 32'h00000000;
    end else if (ap_valid && !HWRITE) begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Zero-wait slave: ready and response are constants held in flops.
  logic       ready_q;
  logic [1:0] resp_q;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ready_q <= 1'b1;
      resp_q  <= HRESP_OKAY;
    end else begin
      ready_q <= 1'b1;
      resp_q  <= HRESP_OKAY;
    end
  end

  assign HRDATA      = rdata_q;
  assign HREADYOUT   = ready_q;
  assign HRESP       = resp_q;
  assign CMP_ON      = cmp_on_q;
  assign CMP_IRQ_ON  = cmp_irq_on_q;
  assign RC_PIN      = rc_pin_q;
  assign LINEAR_CODE = code_q;
  assign DONE        = done_q;
  assign IRQ         = irq_q;

endmodule : erc_top

`default_nettype wire

// file: verification/erc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Conversion checker
module erc_monitor #(
  parameter int BUS_DIV_P  = 50,
  parameter int PRESCALE_P = 8,
  parameter int MODULUS_P  = 255
) (
  input wire logic              CLK,
  input wire logic              RSTN,
  input wire logic              HREADYOUT,
  input wire logic [1:0]        HRESP,
  input wire logic              CMP_OUT,
  input wire logic              CMP_ON,
  input wire logic              CMP_IRQ_ON,
  input wire erc_pkg::erc_pin_s RC_PIN,
  input wire logic              DONE
);
  import erc_pkg::*;
  int unsigned on_cyc_q;
  // A counter, because a full overflow period is far too long to unroll.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      on_cyc_q <= 0;
    end else begin
      on_cyc_q <= CMP_ON ? on_cyc_q + 1 : 0;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_cmp_off;
    $fell(CMP_ON) && $past(RSTN);
  endsequence
  sequence s_done_soon;
    ##[1:6] DONE;
  endsequence
  bus_okay_a: assert property (HREADYOUT && HRESP == HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  pin_release_a: assert property ($rose(CMP_ON) |-> ##[0:2] RC_PIN.oen)
    else $error("pin not released after comparator on");
  irq_with_cmp_a: assert property (CMP_ON |-> CMP_IRQ_ON)
    else $error("comparator on without its interrupt");
  done_pulse_a: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  done_idle_a: assert property (DONE |-> !CMP_ON)
    else $error("done while comparator on");
  end_done_a: assert property (s_cmp_off |-> s_done_soon)
    else $error("no done after conversion end");
  cmp_stop_a: assert property ($rose(CMP_OUT) && CMP_ON |-> ##[2:10] !CMP_ON)
    else $error("comparator event did not end the wait");
  wait_bound_a: assert property (on_cyc_q <= (MODULUS_P + 1) * BUS_DIV_P * PRESCALE_P + 8)
    else $error("wait outlasted timer overflow");
endmodule : erc_monitor
bind erc_top erc_monitor #(.BUS_DIV_P(BUS_DIV_P), .PRESCALE_P(PRESCALE_P), .MODULUS_P(MODULUS_P))
  erc_monitor_inst (.CLK(CLK), .RSTN(RSTN), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CMP_OUT(CMP_OUT),
                    .CMP_ON(CMP_ON), .CMP_IRQ_ON(CMP_IRQ_ON), .RC_PIN(RC_PIN), .DONE(DONE));
`default_nettype wire

// file: verification/erc_rc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Comparator and RC network
module erc_rc_model (
  input wire logic              clk,
  input wire logic              cmp_on,
  input wire erc_pkg::erc_pin_s rc_pin,
  input wire logic [15:0]       charge_cyc,
  output logic                  cmp_out,
  output logic                  rc_i
);
  logic [15:0] chg_q = 16'h0;
  // The capacitor charges only while the pin is released and the comparator is on.
  always @(posedge clk) chg_q <= (cmp_on && rc_pin.oen) ? chg_q + 16'h1 : 16'h0;
  // An all-ones charge time models an input above the measurable range.
  assign cmp_out = cmp_on && rc_pin.oen && charge_cyc != 16'hffff && chg_q >= charge_cyc;
  assign rc_i    = rc_pin.oen ? cmp_out : rc_pin.o;
endmodule : erc_rc_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Testbench
module tb_top;
  import erc_pkg::*;
  typedef struct { logic [15:0] ticks; logic [7:0] raw; logic [7:0] tol; } erc_row_s;
  logic        clk, rst_n, hsel, hwrite, hreadyout, cmp_out, rc_i, cmp_on, cmp_irq_on, done, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic [7:0]  linear_code;
  logic [15:0] charge_cyc;
  erc_pin_s    rc_pin;
  int          n_fail = 0, n_compared = 0, n_done = 0, d0;
  logic [7:0]  tbl [0:15] = '{0, 5, 10, 14, 18, 23, 27, 31, 35, 39, 43, 47, 50, 54, 58, 61};
  erc_row_s    rows [7] = '{'{0, 0, 1}, '{1, 1, 1}, '{2, 2, 1}, '{5, 5, 1}, '{9, 9, 1}, '{12, 12, 1},
                            '{16'hffff, 8'hff, 0}};

  erc_top #(.BUS_DIV_P(1)) erc_top_inst (
    .CLK(clk), .RSTN(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .CMP_OUT(cmp_out), .CMP_ON(cmp_on), .CMP_IRQ_ON(cmp_irq_on), .RC_I(rc_i), .RC_PIN(rc_pin),
    .LINEAR_CODE(linear_code), .DONE(done), .IRQ(irq));
  erc_rc_model erc_rc_model_inst (.clk(clk), .cmp_on(cmp_on), .rc_pin(rc_pin), .charge_cyc(charge_cyc),
                                  .cmp_out(cmp_out), .rc_i(rc_i));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (done === 1'b1) n_done <= n_done + 1;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic chk_in(input string nm, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
    n_compared++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      n_fail++;
      $display("BAD %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask : chk_in
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic convert(input logic [15:0] ticks, input logic park);
    int n;
    charge_cyc <= (ticks == 16'hffff) ? ticks : 16'(ticks * TMR_PRESCALE);
    bus(1'b1, OFF_CTRL, {30'h0, park, 1'b1}, rd);
    n = 0;
    @(negedge clk);
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk("done seen", 32'h1, {31'h0, done});
    @(posedge clk);
  endtask : convert
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial begin
    rst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0; charge_cyc = 16'hffff;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("pin idle", 32'h0, {31'h0, rc_pin.oen});
    bus(1'b0, OFF_IRQ_MASK, 0, rd); chk("mask reset", 32'h0, rd);
    bus(1'b0, OFF_TABLE_BASE, 0, rd); chk("base reset", {24'h0, TABLE_BASE_RST}, rd);
    bus(1'b1, 8'h40, 32'hffffffff, rd);
    bus(1'b0, 8'h40, 0, rd); chk("unmapped", 32'h0, rd);
    foreach (rows[i]) begin
      convert(rows[i].ticks, 1'b0);
      bus(1'b0, OFF_RESULT, 0, rd);
      chk_in("raw", rows[i].raw, rows[i].raw + rows[i].tol, rd[7:0]);
      chk("code", {24'h0, rd[7:0] == RAW_FULL ? 8'd253 : tbl[rd[3:0]]}, {24'h0, rd[15:8]});
      chk("code port", {24'h0, rd[15:8]}, {24'h0, linear_code});
      chk("range flag", {31'h0, rows[i].raw == RAW_FULL}, {31'h0, rd[RES_OOR_BIT]});
    end
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b0, OFF_IRQ_STAT, 0, rd); chk("events", 32'h3, rd);
    bus(1'b0, OFF_IRQ_STAT, 0, rd); chk("events cleared", 32'h0, rd);
    bus(1'b1, OFF_IRQ_MASK, 32'h1, rd);
    convert(16'd3, 1'b0);
    @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b0, OFF_IRQ_STAT, 0, rd); chk("done event", 32'h1, rd);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // One page up, raw count zero lands on table entry 64.
    bus(1'b1, OFF_TABLE_BASE, {24'h0, TABLE_BASE_RST + 8'h01}, rd);
    bus(1'b0, OFF_TABLE_BASE, 0, rd); chk("base moved", {24'h0, TABLE_BASE_RST + 8'h01}, rd);
    convert(16'd0, 1'b0);
    bus(1'b0, OFF_RESULT, 0, rd);
    chk("code next page", 32'd175, {24'h0, rd[15:8]});
    bus(1'b1, OFF_TABLE_BASE, {24'h0, TABLE_BASE_RST}, rd);
    // A second start while busy must be dropped, not queued.
    d0 = n_done;
    charge_cyc <= 16'd80;
    bus(1'b1, OFF_CTRL, 32'h1, rd);
    bus(1'b1, OFF_CTRL, 32'h1, rd);
    bus(1'b0, OFF_STATUS, 0, rd);
    chk("timer before comparator", 32'h5, {29'h0, rd[2:0]});
    repeat (400) @(posedge clk);
    chk("one done", d0 + 1, n_done);
    convert(16'd4, 1'b1);
    repeat (3) @(posedge clk);
    chk("pin parked", 32'h1, {31'h0, rc_pin.oen});
    bus(1'b1, OFF_CTRL, 32'h0, rd);
    repeat (3) @(posedge clk);
    chk("pin discharging", 32'h0, {31'h0, rc_pin.oen});
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
